// File: src/mds_pkg.sv
package mds_pkg;

   // datapath widths
   localparam int ACC_W  = 40;
   localparam int WORD_W = 16;

   // opcode byte values
   localparam logic [7:0] OPC_FORM_REG  = 8'ha3;
   localparam logic [7:0] OPC_FORM_RIND = 8'h83;
   localparam logic [7:0] OPC_FORM_XIND = 8'h93;
   localparam logic [7:0] OPC_SUB2      = 8'h4a;
   localparam logic [7:0] OPC_SUB2R     = 8'h52;

   // fourth byte field positions
   localparam int RRR_LSB = 5;
   localparam int QQQ_LSB = 0;

   // reset values
   localparam logic [ACC_W-1:0] ACC_RST = 40'h00_0000_0000;

   // addressing forms
   typedef enum logic [2:0] {
      MDS_FORM_REG  = 3'b001,
      MDS_FORM_RIND = 3'b010,
      MDS_FORM_XIND = 3'b100
   } mds_form_e;

   // issued instruction
   typedef struct packed {
      logic [31:0]       instr;
      logic [WORD_W-1:0] op1;
      logic [WORD_W-1:0] op2;
   } mds_issue_s;

   // flag set
   typedef struct packed {
      logic overflow_flag;
      logic sticky_saturation_flag;
      logic extension_used_flag;
      logic sticky_overflow_flag;
      logic carry_borrow_flag;
      logic zero_result_flag;
      logic negative_result_flag;
   } mds_flags_s;

   // decode result
   typedef struct packed {
      logic      hit;
      logic      reversed;
      mds_form_e form;
      logic [2:0] rrr;
      logic [2:0] qqq;
   } mds_dec_s;

endpackage

// File: src/mds_decode.sv
`timescale 1ns/1ps
// combinational recogniser of the two doubled-subtract encodings
module mds_decode
   import mds_pkg::*;
(
   // instruction word, first byte in bits 31:24
   input  wire logic [31:0] instr,
   // decode result
   output mds_dec_s         dec
);

   logic [7:0] b0;
   logic [7:0] b2;
   logic [7:0] b3;
   logic       form_ok;
   logic       low_ok;

   assign b0 = instr[31:24];
   assign b2 = instr[15:8];
   assign b3 = instr[7:0];

   // form selection and fixed-zero fields of the fourth byte
   always_comb begin
      dec.form = MDS_FORM_REG;
      form_ok  = 1'b1;
      low_ok   = (b3[4:3] == 2'h0);
      unique case (b0)
         OPC_FORM_REG: begin
            low_ok = (b3[4:0] == 5'h00);
         end
         OPC_FORM_RIND: dec.form = MDS_FORM_RIND;
         OPC_FORM_XIND: dec.form = MDS_FORM_XIND;
         default: form_ok = 1'b0;
      endcase
      dec.reversed = (b2 == OPC_SUB2R);              // RQ10
      dec.hit      = form_ok && low_ok
                     && (b2 == OPC_SUB2 || b2 == OPC_SUB2R); // RQ9 RQ10
      dec.rrr      = b3[RRR_LSB +: 3];               // RQ12
      dec.qqq      = (b0 == OPC_FORM_REG) ? 3'h0
                     : b3[QQQ_LSB +: 3];             // RQ12
   end

endmodule

// File: src/mds_unit.sv
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - operand is sign-extended second||first word
// RQ2 - operand is doubled before subtracting
// RQ3 - normal: accumulator minus doubled operand
// RQ4 - reversed: doubled operand minus accumulator
// RQ5 - unrepresentable result sets overflow and sticky
// RQ6 - saturation sets sticky saturation flag
// RQ7 - borrow sets carry flag, else cleared
// RQ8 - zero and negative flags from result
// RQ9 - normal encoding: third byte 4a
// RQ10 - reversed encoding: third byte 52
// RQ11 - extension flag when top bits used
// RQ12 - qqq is post-modify, rrr is option
// RQ13 - one signed step, flags from result
module mds_unit
   import mds_pkg::*;
(
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   // issue side
   input  wire logic             issue_valid,
   input  mds_issue_s            issue,
   input  wire logic             sat_enable,
   // accumulator and flags
   output logic [ACC_W-1:0]      mac_accumulator,
   output mds_flags_s            flags,
   // executed instruction details
   output logic                  done_pulse,
   output logic [2:0]            post_mod_sel,
   output logic [2:0]            option_sel,
   output logic                  index_pointer_form
);

   mds_dec_s          dec;
   logic [ACC_W-1:0]  acc_r;
   logic [ACC_W-1:0]  acc_nxt;
   mds_flags_s        flags_r;
   mds_flags_s        flags_nxt;
   logic              done_r;
   logic              done_nxt;
   logic [2:0]        qqq_r;
   logic [2:0]        qqq_nxt;
   logic [2:0]        rrr_r;
   logic [2:0]        rrr_nxt;
   logic              xind_r;
   logic              xind_nxt;
   logic [ACC_W-1:0]  tmp;
   logic [ACC_W+1:0]  wide;
   logic [ACC_W+1:0]  lhs;
   logic [ACC_W+1:0]  rhs;
   logic              ovf;
   logic              borrow;
   logic [ACC_W-1:0]  res;
   logic              sat_hit;

   // instruction recogniser
   mds_decode u_dec (
      .instr (issue.instr),
      .dec   (dec)
   );

   // operand assembly and subtraction in 42 bits
   always_comb begin
      tmp = {{(ACC_W-2*WORD_W){issue.op2[WORD_W-1]}},
             issue.op2, issue.op1};                          // RQ1
      lhs = dec.reversed ? {{1{tmp[ACC_W-1]}}, tmp, 1'b0}    // RQ2 RQ4
                         : {{2{acc_r[ACC_W-1]}}, acc_r};     // RQ3
      rhs = dec.reversed ? {{2{acc_r[ACC_W-1]}}, acc_r}      // RQ4
                         : {{1{tmp[ACC_W-1]}}, tmp, 1'b0};   // RQ2 RQ3
      wide   = lhs - rhs;                                    // RQ13
      ovf    = (wide[ACC_W+1:ACC_W-1] != {3{wide[ACC_W-1]}}); // RQ5
      borrow = (lhs[ACC_W-1:0] < rhs[ACC_W-1:0]);            // RQ7
   end

   // saturation on overflow when enabled
   always_comb begin
      sat_hit = sat_enable && ovf;                           // RQ6
      res     = wide[ACC_W-1:0];
      if (sat_hit) begin
         res = wide[ACC_W+1] ? {1'b1, {(ACC_W-1){1'b0}}}
                             : {1'b0, {(ACC_W-1){1'b1}}};
      end
   end

   // next accumulator, flags and details
   always_comb begin
      acc_nxt   = acc_r;
      flags_nxt = flags_r;
      done_nxt  = 1'b0;
      qqq_nxt   = qqq_r;
      rrr_nxt   = rrr_r;
      xind_nxt  = xind_r;
      if (issue_valid && dec.hit) begin
         acc_nxt  = res;                                     // RQ3 RQ4
         done_nxt = 1'b1;
         qqq_nxt  = dec.qqq;                                 // RQ12
         rrr_nxt  = dec.rrr;                                 // RQ12
         xind_nxt = (dec.form == MDS_FORM_XIND);
         flags_nxt.overflow_flag = ovf;                      // RQ5
         if (ovf) begin
            flags_nxt.sticky_overflow_flag = 1'b1;           // RQ5
         end
         if (sat_hit) begin
            flags_nxt.sticky_saturation_flag = 1'b1;         // RQ6
         end
         flags_nxt.carry_borrow_flag = borrow;               // RQ7
         flags_nxt.zero_result_flag  = (res == '0);          // RQ8 RQ13
         flags_nxt.negative_result_flag = res[ACC_W-1];      // RQ8
         flags_nxt.extension_used_flag =
            (res[ACC_W-1:31] != {(ACC_W-31){res[31]}});       // RQ11
      end
   end

   // state registers
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         acc_r   <= ACC_RST;
         flags_r <= '0;
         done_r  <= 1'b0;
         qqq_r   <= 3'h0;
         rrr_r   <= 3'h0;
         xind_r  <= 1'b0;
      end else begin
         acc_r   <= acc_nxt;
         flags_r <= flags_nxt;
         done_r  <= done_nxt;
         qqq_r   <= qqq_nxt;
         rrr_r   <= rrr_nxt;
         xind_r  <= xind_nxt;
      end
   end

   assign mac_accumulator    = acc_r;
   assign flags              = flags_r;
   assign done_pulse         = done_r;
   assign post_mod_sel       = qqq_r;
   assign option_sel         = rrr_r;
   assign index_pointer_form = xind_r;

   // checks
   sequence s_issue_norm;
      issue_valid && dec.hit && !dec.reversed;
   endsequence

   sequence s_issue_rev;
      issue_valid && dec.hit && dec.reversed;
   endsequence

   a_norm_result: assert property (@(posedge core_clk) disable iff (sys_rst)
      s_issue_norm and !ovf |=> acc_r == $past(acc_r)
         - {$past(tmp[ACC_W-2:0]), 1'b0})                    // RQ3
      else $error("normal result wrong");

   a_rev_result: assert property (@(posedge core_clk) disable iff (sys_rst)
      s_issue_rev and !ovf |=> acc_r == {$past(tmp[ACC_W-2:0]), 1'b0}
         - $past(acc_r))                                     // RQ4
      else $error("reversed result wrong");

   a_ovf_sticky: assert property (@(posedge core_clk) disable iff (sys_rst)
      issue_valid && dec.hit && ovf |=> flags_r.overflow_flag
         && flags_r.sticky_overflow_flag)                    // RQ5
      else $error("overflow flags not set");

   a_sticky_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      $past(flags_r.sticky_overflow_flag) && !$past(sys_rst)
         |-> flags_r.sticky_overflow_flag)                   // RQ5
      else $error("sticky overflow lost");

   a_sat_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
      issue_valid && dec.hit && sat_enable && ovf
         |=> flags_r.sticky_saturation_flag)                 // RQ6
      else $error("saturation flag not set");

   a_zero_neg: assert property (@(posedge core_clk) disable iff (sys_rst)
      done_r |-> flags_r.zero_result_flag == (acc_r == '0)
         && flags_r.negative_result_flag == acc_r[ACC_W-1])  // RQ8
      else $error("zero or negative flag wrong");

   a_ext_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
      done_r |-> flags_r.extension_used_flag
         == (acc_r[ACC_W-1:31] != {(ACC_W-31){acc_r[31]}}))  // RQ11
      else $error("extension flag wrong");

   a_idle_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      !(issue_valid && dec.hit) |=> $stable(acc_r) && !done_r) // RQ9 RQ10
      else $error("accumulator changed without instruction");

   a_decode_hit: assert property (@(posedge core_clk) disable iff (sys_rst)
      issue_valid && issue.instr[31:24] == OPC_FORM_REG
         && issue.instr[15:8] == OPC_SUB2 && issue.instr[4:0] == 5'h00
         |=> done_r)                                         // RQ9
      else $error("register form not recognised");

endmodule

// File: bench/mds_issuer.sv
`timescale 1ns/1ps
// issuing side: holds an instruction while asked, else a moving pattern
module mds_issuer
   import mds_pkg::*;
(
   // clock
   input  wire logic core_clk,
   // request from the bench
   input  wire logic req,
   input  mds_issue_s req_d,
   // issue port
   output logic       issue_valid,
   output mds_issue_s issue
);
   mds_issue_s idle_r = '0;
   // flips every cycle so a stale word never looks valid
   always_ff @(posedge core_clk) begin
      idle_r <= ~idle_r;
   end
   // drive the instruction only while it is requested
   always_comb begin
      issue_valid = req;
      issue       = req ? req_d : idle_r;
   end
endmodule

// File: bench/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin \
   cmp_count++; \
   if ((s) !== (e)) begin \
      errors++; \
      $display("MISMATCH %s exp %h got %h", n, e, s); \
   end \
end
module tb
   import mds_pkg::*;
   ;
   logic              core_clk, sys_rst, req, sat_enable, issue_valid;
   logic              done_pulse, index_pointer_form;
   logic [2:0]        post_mod_sel, option_sel;
   logic [ACC_W-1:0]  mac_accumulator, exp_acc;
   mds_issue_s        req_d, issue;
   mds_flags_s        flags, exp_f;
   int                errors, cmp_count;
   logic [7:0]        fbs [3] = '{OPC_FORM_REG, OPC_FORM_RIND, OPC_FORM_XIND};

   mds_issuer mds_issuer_i(.core_clk(core_clk), .req(req), .req_d(req_d),
      .issue_valid(issue_valid), .issue(issue));
   mds_unit mds_unit_i(.core_clk(core_clk), .sys_rst(sys_rst),
      .issue_valid(issue_valid), .issue(issue), .sat_enable(sat_enable),
      .mac_accumulator(mac_accumulator), .flags(flags),
      .done_pulse(done_pulse), .post_mod_sel(post_mod_sel),
      .option_sel(option_sel), .index_pointer_form(index_pointer_form));

   // clock generator
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task automatic final_report();
      if (errors == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // reference step: doubled operand, 42-bit difference, then flags
   task automatic model(input logic rev, input logic [15:0] o1, o2);
      logic [41:0] d, a, r;
      logic [39:0] v;
      logic        ov;
      d = {{10{o2[15]}}, o2, o1} << 1;
      a = {{2{exp_acc[39]}}, exp_acc};
      r = rev ? d - a : a - d;
      ov = r[41:39] != 3'h0 && r[41:39] != 3'h7;
      exp_f.carry_borrow_flag = rev ? d[39:0] < exp_acc : exp_acc < d[39:0];
      v = r[39:0];
      if (sat_enable && ov) begin
         v = r[41] ? 40'h80_0000_0000 : 40'h7f_ffff_ffff;
         exp_f.sticky_saturation_flag = 1'b1;
      end
      exp_f.overflow_flag = ov;
      exp_f.sticky_overflow_flag |= ov;
      exp_f.extension_used_flag = v[39:31] != {9{v[31]}};
      exp_f.zero_result_flag = v == 40'h0;
      exp_f.negative_result_flag = v[39];
      exp_acc = v;
   endtask

   task automatic do_reset();
      sys_rst = 1'b1;
      repeat (16) @(posedge core_clk);
      #1;
      `CHK("acc", ACC_RST, mac_accumulator)
      `CHK("flags", 7'h0, flags)
      `CHK("sel", 7'h0, {done_pulse, post_mod_sel, option_sel})
      `CHK("idx", 1'b0, index_pointer_form)
      sys_rst = 1'b0;
      exp_acc = ACC_RST;
      exp_f = '0;
   endtask

   // one instruction taken at the next edge; request is left held
   task automatic go(input logic rev, input logic [7:0] fb,
                     input logic [2:0] rrr, qqq, input logic [15:0] o1, o2);
      req = 1'b1;
      req_d = {fb, 8'h12, rev ? OPC_SUB2R : OPC_SUB2, rrr, 2'h0, qqq, o1, o2};
      @(posedge core_clk);
      #1;
      model(rev, o1, o2);
      `CHK("acc", exp_acc, mac_accumulator)
      `CHK("flags", exp_f, flags)
      `CHK("done", 1'b1, done_pulse)
      `CHK("rrr", rrr, option_sel)
      `CHK("qqq", fb == OPC_FORM_REG ? 3'h0 : qqq, post_mod_sel)
      `CHK("idx", fb == OPC_FORM_XIND, index_pointer_form)
   endtask

   task automatic idle();
      req = 1'b0;
      @(posedge core_clk);
      #1;
      `CHK("done", 1'b0, done_pulse)
      `CHK("acc", exp_acc, mac_accumulator)
   endtask

   // every form with both directions, zero, negative and borrow cases
   task automatic t_forms();
      go(1'b0, OPC_FORM_REG, 3'h0, 3'h0, 16'h0000, 16'h0000);
      idle();
      for (int f = 0; f < 3; f++) begin
         for (int rv = 0; rv < 2; rv++) begin
            go(rv[0], fbs[f], 3'h5 + f[2:0], f == 0 ? 3'h0 : 3'h3 + f[2:0],
               16'h8001 + f[15:0], f == 1 ? 16'hfff0 : 16'h0123);
            idle();
         end
      end
   endtask

   // malformed words must leave the accumulator untouched and raise no done pulse
   task automatic t_refuse();
      logic [31:0] bad [5] = '{32'ha3124a08, 32'h83124a10, 32'ha3120a00,
                               32'hc3124a00, 32'ha3125201};
      foreach (bad[i]) begin
         req = 1'b1;
         req_d = {bad[i], 16'h1234, 16'h0001};
         @(posedge core_clk);
         #1;
         `CHK("done", 1'b0, done_pulse)
         `CHK("acc", exp_acc, mac_accumulator)
         req = 1'b0;
         @(posedge core_clk);
         #1;
      end
   endtask

   // back-to-back climb past the positive limit, then a calm step
   task automatic t_sat(input logic s);
      sat_enable = s;
      for (int i = 0; i < 130; i++)
         go(1'b0, OPC_FORM_RIND, 3'h1, 3'h2, 16'h0000, 16'h8000);
      go(1'b1, OPC_FORM_XIND, 3'h2, 3'h1, 16'h0001, 16'h0000);
      idle();
   endtask

   // give up if the sequence hangs
   initial begin
      #150000;
      errors++;
      final_report();
   end

   initial begin
      errors = 0;
      cmp_count = 0;
      sys_rst = 1'b1;
      req = 1'b0;
      sat_enable = 1'b0;
      req_d = '0;
      do_reset();
      t_forms();
      t_refuse();
      t_sat(1'b0);
      do_reset();
      t_sat(1'b1);
      final_report();
   end
endmodule
